/* rtl/pll_regs_pkg.sv */
// package: register map, field positions and reset values of the pll block
package pll_regs_pkg;

    // register addresses (serial configuration port word addresses)
    localparam logic [7:0] ADDR_POWER_DOWN = 8'h05;
    localparam logic [7:0] ADDR_CAL_WORD   = 8'h06;
    localparam logic [7:0] ADDR_FLAGS      = 8'h07;
    localparam logic [7:0] ADDR_LAST       = 8'h07;

    // power-down register fields
    localparam int PD_VCOBUF_REG = 10;
    localparam int PD_VCO_REG    = 9;
    localparam int PD_VCO_BUF    = 8;
    localparam int PD_CP_REG     = 7;
    localparam int PD_LOCKDET    = 6;
    localparam int PD_FB_PRESC   = 5;
    localparam int PD_PRESC_A    = 4;
    localparam int PD_PFD        = 2;
    localparam int PD_MAIN_PRESC = 1;
    localparam int PD_INPUT_REG  = 0;

    // power-down reset value: both feedback prescaler paths down
    localparam logic [15:0] PD_RESET      = 16'h0030;
    // reserved bits 15..11 and bit 3 are not stored
    localparam logic [15:0] PD_WRITE_MASK = 16'h07f7;

    // flag register fields
    localparam int FL_LOCK_ANALOG = 11;
    localparam int FL_VCO_CAL_RDY = 10;
    localparam int FL_NVM_RD_ERR  = 9;
    localparam int FL_NVM_WR_ERR  = 8;
    localparam int FL_REG_RD_ERR  = 7;
    localparam int FL_REG_WR_ERR  = 6;
    localparam int FL_CRC_ERR     = 5;
    localparam int FL_NVM_BUSY    = 4;
    localparam int FL_CAL_DONE    = 3;
    localparam int FL_CFG_DONE    = 2;
    localparam int FL_UNLOCK_STKY = 1;
    localparam int FL_LOCK_DET    = 0;
    localparam logic [15:0] FLAGS_RESET = 16'h0000;
    localparam logic [15:0] CAL_RESET   = 16'h0000;

    // register access request from the serial port
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    // device state events feeding the status logic
    typedef struct packed {
        logic        por_busy;
        logic        cal_busy;
        logic        cal_done;
        logic        cfg_done;
        logic        lock_analog;
        logic        lock_freq;
        logic        vco_cal_ready;
        logic        nvm_rd_phase;
        logic        nvm_wr_phase;
        logic        nvm_op_issue;
        logic        nvm_busy;
        logic        crc_err_set;
        logic        crc_err_clr;
        logic        recal_start;
        logic        hard_reset;
        logic [15:0] cal_word;
    } dev_evt_t;

endpackage

/* rtl/pll_status_flags.sv */
// status flag register: sticky, clear-on-read and live flags
module pll_status_flags
    import pll_regs_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   srst_in,
    // device events
    input  wire pll_regs_pkg::dev_evt_t evt_in,
    // register port errors
    input  wire logic                   reg_rd_err_in,
    input  wire logic                   reg_wr_err_in,
    // clear-on-read strobe for this register
    input  wire logic                   flags_read_in,
    // flag word
    output logic [15:0]                 flags_out
);
    logic [15:0] flags_r;
    logic [15:0] flags_nxt;
    wire         nvm_rd_set = evt_in.nvm_op_issue & evt_in.nvm_rd_phase;
    wire         nvm_wr_set = evt_in.nvm_op_issue & evt_in.nvm_wr_phase;
    wire         lost_lock  = flags_r[FL_LOCK_DET] & ~evt_in.lock_freq;

    // next flag word; set beats clear on the same cycle
    always_comb begin
        flags_nxt = flags_r;
        flags_nxt[FL_LOCK_ANALOG] = evt_in.lock_analog;
        flags_nxt[FL_VCO_CAL_RDY] = evt_in.vco_cal_ready;
        flags_nxt[FL_NVM_RD_ERR]  = nvm_rd_set |
            (flags_r[FL_NVM_RD_ERR] & ~flags_read_in);
        flags_nxt[FL_NVM_WR_ERR]  = nvm_wr_set |
            (flags_r[FL_NVM_WR_ERR] & ~flags_read_in);
        flags_nxt[FL_REG_RD_ERR]  = flags_r[FL_REG_RD_ERR] | reg_rd_err_in;
        flags_nxt[FL_REG_WR_ERR]  = flags_r[FL_REG_WR_ERR] | reg_wr_err_in;
        flags_nxt[FL_CRC_ERR]     = evt_in.crc_err_set |
            (flags_r[FL_CRC_ERR] & ~evt_in.crc_err_clr);
        flags_nxt[FL_NVM_BUSY]    = evt_in.nvm_busy;
        flags_nxt[FL_CAL_DONE]    = evt_in.cal_done;
        flags_nxt[FL_CFG_DONE]    = evt_in.cfg_done;
        // only recalibration or the pin reset clears the sticky unlock
        flags_nxt[FL_UNLOCK_STKY] = lost_lock | (flags_r[FL_UNLOCK_STKY] &
            ~(evt_in.recal_start | evt_in.hard_reset));
        flags_nxt[FL_LOCK_DET]    = evt_in.lock_freq;
        flags_nxt[15:12]          = 4'h0;
    end

    // flag register
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            flags_r <= FLAGS_RESET;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    assign flags_out = flags_r;

    // nvm read error raised the cycle after a clashing operation
    a_nvm_rd_set: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        nvm_rd_set |=> flags_r[FL_NVM_RD_ERR])
        else $error("nvm read error flag not set");
    // nvm write error raised the cycle after a clashing operation
    a_nvm_wr_set: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        nvm_wr_set |=> flags_r[FL_NVM_WR_ERR])
        else $error("nvm write error flag not set");
    // a read of the flag word drops the read error unless set again
    a_nvm_rd_clear: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (flags_read_in && !nvm_rd_set) |=> !flags_r[FL_NVM_RD_ERR])
        else $error("nvm read error flag not cleared by read");
    // sticky unlock survives everything but recalibration or pin reset
    a_unlock_sticky: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (flags_r[FL_UNLOCK_STKY] && !evt_in.recal_start
         && !evt_in.hard_reset) |=> flags_r[FL_UNLOCK_STKY])
        else $error("sticky unlock lost without recalibration");
    // any loss of lock is recorded
    a_unlock_set: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        lost_lock |=> flags_r[FL_UNLOCK_STKY])
        else $error("loss of lock not recorded");
    // busy mirrors the operation one cycle late, not across a reset
    a_busy_follows: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        !$past(srst_in) |-> flags_r[FL_NVM_BUSY] == $past(evt_in.nvm_busy))
        else $error("nvm busy flag does not track operation");
endmodule

/* rtl/pll_power_status_regs.sv */
// pll power-down control, calibration word and status register bank
//
// Function
// - bits 10,9,8 power down VCO parts
// - bit 7 powers down charge pump regulator
// - bit 6 disables lock detector, resets zero
// - bit 5 feedback prescaler, resets to one
// - bit 4 low during reset, then one
// - bit 2 high during calibration, then zero
// - bit 1 low during reset, then one
// - address 6h reads calibration word, resets zero
// - address 7h holds status flags, resets zero
// - nvm read/write errors set, clear on read
// - sticky unlock cleared only by recal/reset
// - nvm busy high during erase/program
module pll_power_status_regs
    import pll_regs_pkg::*;
(
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   srst_in,
    // register access from the serial configuration port
    input  wire pll_regs_pkg::reg_req_t req_in,
    output logic [15:0]                 rdata_out,
    // device state
    input  wire pll_regs_pkg::dev_evt_t evt_in,
    // power-down controls, 1 = powered down
    output logic                        vco_buffer_regulator_off_out,
    output logic                        vco_regulator_off_out,
    output logic                        vco_buffer_off_out,
    output logic                        charge_pump_regulator_off_out,
    output logic                        lock_detector_off_out,
    output logic                        fb_prescaler_off_out,
    output logic                        prescaler_a_off_out,
    output logic                        pfd_off_out,
    output logic                        main_prescaler_off_out,
    output logic                        input_regulator_off_out
);
    logic [15:0] pd_r;
    logic [15:0] pd_nxt;
    logic [15:0] cal_r;
    logic [15:0] rdata_r;
    logic        por_busy_d_r;
    logic        cal_busy_d_r;
    logic [15:0] flags;

    // decodes of the port address
    wire hit_pd    = (req_in.addr == ADDR_POWER_DOWN);
    wire hit_cal   = (req_in.addr == ADDR_CAL_WORD);
    wire hit_flags = (req_in.addr == ADDR_FLAGS);
    wire over_addr = (req_in.addr > ADDR_LAST);
    wire pd_write  = req_in.wr & hit_pd;
    wire flags_rd  = req_in.rd & hit_flags;
    // device events that seize bits: end of reset, end of calibration
    wire por_end   = por_busy_d_r & ~evt_in.por_busy;
    wire cal_end   = cal_busy_d_r & ~evt_in.cal_busy;

    // power-down next value; device holds win while active, then
    // software owns every bit again (held bits of a write during hold are overridden)
    always_comb begin
        pd_nxt = pd_r;
        if (pd_write) begin
            pd_nxt = req_in.wdata & PD_WRITE_MASK;
        end
        if (evt_in.por_busy) begin
            pd_nxt[PD_PRESC_A]    = 1'b0;
            pd_nxt[PD_MAIN_PRESC] = 1'b0;
        end else if (por_end) begin
            pd_nxt[PD_PRESC_A]    = 1'b1;
            pd_nxt[PD_MAIN_PRESC] = 1'b1;
        end
        if (evt_in.cal_busy) begin
            pd_nxt[PD_PFD] = 1'b1;
        end else if (cal_end) begin
            pd_nxt[PD_PFD] = 1'b0;
        end
    end

    // power-down register and phase trackers
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pd_r         <= PD_RESET;
            por_busy_d_r <= 1'b0;
            cal_busy_d_r <= 1'b0;
        end else begin
            pd_r         <= pd_nxt;
            por_busy_d_r <= evt_in.por_busy;
            cal_busy_d_r <= evt_in.cal_busy;
        end
    end

    // calibration word captured when calibration completes
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cal_r <= CAL_RESET;
        end else if (cal_end) begin
            cal_r <= evt_in.cal_word;
        end
    end

    // status flags
    pll_status_flags u_flags (
        .mclk_in       (mclk_in),
        .srst_in       (srst_in),
        .evt_in        (evt_in),
        .reg_rd_err_in (req_in.rd & over_addr),
        .reg_wr_err_in (req_in.wr & over_addr),
        .flags_read_in (flags_rd),
        .flags_out     (flags)
    );

    // read selection; unmapped addresses read zero
    wire [15:0] rd_sel = hit_pd    ? pd_r :
                         hit_cal   ? cal_r :
                         hit_flags ? flags : 16'h0000;

    // read data registered and held until the next read
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rdata_r <= 16'h0000;
        end else if (req_in.rd) begin
            rdata_r <= rd_sel;
        end
    end
    assign rdata_out = rdata_r;

    // each stored bit drives its block directly
    assign vco_buffer_regulator_off_out  = pd_r[PD_VCOBUF_REG];
    assign vco_regulator_off_out         = pd_r[PD_VCO_REG];
    assign vco_buffer_off_out            = pd_r[PD_VCO_BUF];
    assign charge_pump_regulator_off_out = pd_r[PD_CP_REG];
    assign lock_detector_off_out         = pd_r[PD_LOCKDET];
    assign fb_prescaler_off_out          = pd_r[PD_FB_PRESC];
    assign prescaler_a_off_out           = pd_r[PD_PRESC_A];
    assign pfd_off_out                   = pd_r[PD_PFD];
    assign main_prescaler_off_out        = pd_r[PD_MAIN_PRESC];
    // kill switch kept as written; software is expected to leave it 0
    assign input_regulator_off_out       = pd_r[PD_INPUT_REG];

    // prescaler enables forced low while power-on reset runs
    a_por_hold: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        evt_in.por_busy |=> (!pd_r[PD_PRESC_A] && !pd_r[PD_MAIN_PRESC]))
        else $error("prescalers not held low during reset");

    // both prescaler bits set once power-on reset is over
    a_por_release: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        por_end |=> (pd_r[PD_PRESC_A] && pd_r[PD_MAIN_PRESC]))
        else $error("prescalers not set after reset");

    // pfd enabled on the cycle after calibration ends
    a_pfd_cal: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        cal_end |=> !pd_r[PD_PFD])
        else $error("pfd not enabled after calibration");

    // pfd held down while calibration runs
    a_pfd_hold: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        evt_in.cal_busy |=> pd_r[PD_PFD])
        else $error("pfd not held down during calibration");

    // a write with no device hold lands whole
    a_sw_write: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (pd_write && !evt_in.por_busy && !por_end && !evt_in.cal_busy
         && !cal_end) |=> pd_r == ($past(req_in.wdata) & PD_WRITE_MASK))
        else $error("power-down write not stored");

    // charge pump, lock detector and feedback prescaler follow writes
    a_cp_pin: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        pd_write |=> {charge_pump_regulator_off_out, lock_detector_off_out,
                      fb_prescaler_off_out}
                     == $past(req_in.wdata[PD_CP_REG:PD_FB_PRESC]))
        else $error("charge pump controls do not follow write");

    // the three vco controls follow writes; no device hold touches them
    a_vco_write: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        pd_write |=> {vco_buffer_regulator_off_out, vco_regulator_off_out,
                      vco_buffer_off_out}
                     == $past(req_in.wdata[PD_VCOBUF_REG:PD_VCO_BUF]))
        else $error("vco controls do not follow write");

    // every register is back at its reset value after a reset edge
    a_reset_value: assert property (@(posedge mclk_in)
        srst_in |=> (pd_r == PD_RESET && cal_r == CAL_RESET
                     && flags == FLAGS_RESET))
        else $error("register not at reset value after reset");

    // calibration word reads back as stored
    a_cal_read: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (req_in.rd && hit_cal) |=> rdata_out == $past(cal_r))
        else $error("calibration word read wrong");

    // calibration word is taken from the device at the end of calibration
    a_cal_capture: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        cal_end |=> cal_r == $past(evt_in.cal_word))
        else $error("calibration word not captured");

    // calibration word is read-only: port writes never move it
    a_cal_readonly: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        !cal_end |=> $stable(cal_r))
        else $error("calibration word changed without calibration");

    // flag word reads back as held on the read edge
    a_flags_read: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (req_in.rd && hit_flags) |=> rdata_out == $past(flags))
        else $error("flag word read wrong");

    // reading past the last register raises the read error
    a_addr_err: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (req_in.rd && over_addr) |=> flags[FL_REG_RD_ERR])
        else $error("read address error not flagged");

    // writing past the last register raises the write error
    a_wr_err: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        (req_in.wr && over_addr) |=> flags[FL_REG_WR_ERR])
        else $error("write address error not flagged");

    // read data stands until the next read
    a_rdata_hold: assert property (@(posedge mclk_in)
        disable iff (srst_in)
        !req_in.rd |=> $stable(rdata_out))
        else $error("read data changed without a read");
endmodule

/* tb/tb_top.sv */
// self-checking bench for the pll power-down and status register bank
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import pll_regs_pkg::*;

    logic        mclk_in;
    logic        srst_in;
    reg_req_t    req_in;
    dev_evt_t    evt_in;
    logic [15:0] rdata_out;
    logic [9:0]  offs;
    logic [15:0] outs;
    logic [15:0] pd;
    logic [15:0] cw;
    logic [15:0] d;
    logic [31:0] x;
    int          errors;
    int          checks_done;
    int          cyc;
    int          m_pd;
    int          m_fl;
    int          m_cw;
    int          nf;
    bit          m_por;
    bit          m_cal;
    int          rd_q[$];

    // power outputs packed back into register bit positions
    assign outs = {5'h0, offs[9:3], 1'b0, offs[2:0]};

    pll_power_status_regs dut (
        .mclk_in                       (mclk_in),
        .srst_in                       (srst_in),
        .req_in                        (req_in),
        .rdata_out                     (rdata_out),
        .evt_in                        (evt_in),
        .vco_buffer_regulator_off_out  (offs[9]),
        .vco_regulator_off_out         (offs[8]),
        .vco_buffer_off_out            (offs[7]),
        .charge_pump_regulator_off_out (offs[6]),
        .lock_detector_off_out         (offs[5]),
        .fb_prescaler_off_out          (offs[4]),
        .prescaler_a_off_out           (offs[3]),
        .pfd_off_out                   (offs[2]),
        .main_prescaler_off_out        (offs[1]),
        .input_regulator_off_out       (offs[0])
    );

    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    function automatic logic [15:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x[15:0];
    endfunction

    task automatic wrap_up();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // all bus tasks start and end on a falling edge
    task automatic step();
        @(negedge mclk_in);
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        req_in.wr = 1'b1;
        req_in.addr = a;
        req_in.wdata = v;
        step();
        req_in.wr = 1'b0;
    endtask

    task automatic rdx(input logic [7:0] a, input logic [15:0] exp);
        req_in.rd = 1'b1;
        req_in.addr = a;
        step();
        req_in.rd = 1'b0;
        chk(rdata_out, exp);
        chk(rdata_out, 16'(rd_q.pop_front()));
    endtask

    // cycle ceiling: the whole sequence needs well under a thousand cycles
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 5000) begin
            errors++;
            wrap_up();
        end
    end

    // reference model; a read queues the value held before its edge
    always @(posedge mclk_in) begin
        if (srst_in) begin
            m_pd = PD_RESET;
            m_fl = 0;
            m_cw = 0;
            m_por = 1'b0;
            m_cal = 1'b0;
            rd_q.delete();
        end else begin
            if (req_in.rd)
                rd_q.push_back(req_in.addr == 8'h05 ? m_pd :
                               req_in.addr == 8'h06 ? m_cw :
                               req_in.addr == 8'h07 ? m_fl : 0);
            if (req_in.wr && req_in.addr == 8'h05)
                m_pd = req_in.wdata & PD_WRITE_MASK;
            // device holds win over a write in the same cycle
            if (evt_in.por_busy || m_por) begin
                m_pd[4] = !evt_in.por_busy;
                m_pd[1] = !evt_in.por_busy;
            end
            if (evt_in.cal_busy || m_cal)
                m_pd[2] = evt_in.cal_busy;
            if (m_cal && !evt_in.cal_busy)
                m_cw = evt_in.cal_word;
            m_por = evt_in.por_busy;
            m_cal = evt_in.cal_busy;
            // stored flags first cleared, then set; set wins
            nf = m_fl & 32'h0000_03e2;
            if (req_in.rd && req_in.addr == 8'h07) begin
                nf[9] = 1'b0;
                nf[8] = 1'b0;
            end
            if (evt_in.crc_err_clr)
                nf[5] = 1'b0;
            if (evt_in.recal_start || evt_in.hard_reset)
                nf[1] = 1'b0;
            nf[1] |= m_fl[0] & ~evt_in.lock_freq;
            nf[9] |= evt_in.nvm_op_issue & evt_in.nvm_rd_phase;
            nf[8] |= evt_in.nvm_op_issue & evt_in.nvm_wr_phase;
            nf[7] |= req_in.rd & (req_in.addr > 8'h07);
            nf[6] |= req_in.wr & (req_in.addr > 8'h07);
            nf[5] |= evt_in.crc_err_set;
            nf[11] = evt_in.lock_analog;
            nf[10] = evt_in.vco_cal_ready;
            nf[4] = evt_in.nvm_busy;
            nf[3] = evt_in.cal_done;
            nf[2] = evt_in.cfg_done;
            nf[0] = evt_in.lock_freq;
            m_fl = nf;
        end
    end

    // power outputs compared with the model at every falling edge
    always @(negedge mclk_in) begin
        chk(outs, 16'(m_pd));
    end

    initial begin
        x = 32'h2a4a;
        req_in = '0;
        evt_in = '0;
        srst_in = 1'b1;
        repeat (6) step();
        srst_in = 1'b0;
        step();
        pd = PD_RESET;
        chk(outs, pd);
        rdx(8'h05, pd);
        rdx(8'h06, 16'h0000);
        rdx(8'h07, 16'h0000);
        // prescaler enables held low while power-on reset runs
        wr(8'h05, 16'h07f6);
        evt_in.por_busy = 1'b1;
        step();
        step();
        pd = 16'h07f6 & ~16'h0012;
        chk(outs, pd);
        wr(8'h05, 16'h0012);
        pd = 16'h0000;
        chk(outs, pd);
        evt_in.por_busy = 1'b0;
        step();
        step();
        pd = 16'h0012;
        chk(outs, pd);
        wr(8'h05, 16'h0000);
        pd = 16'h0000;
        rdx(8'h05, pd);
        // pfd held down until calibration ends, word taken at the end
        cw = rnd();
        evt_in.cal_word = cw;
        evt_in.cal_busy = 1'b1;
        step();
        step();
        chk(outs, 16'h0004);
        evt_in.cal_busy = 1'b0;
        step();
        step();
        chk(outs, 16'h0000);
        evt_in.cal_word = ~cw;
        rdx(8'h06, cw);
        // random power words; bit 0 and reserved bits left zero
        for (int i = 0; i < 8; i++) begin
            d = rnd() & 16'h07f6;
            wr(8'h05, d);
            pd = d;
            chk(outs, pd);
            rdx(8'h05, pd);
            wr(8'h06, rnd());
            wr(8'h07, rnd());
            rdx(8'h06, cw);
            rdx(8'h07, 16'h0000);
        end
        // live flags follow their sources
        evt_in.cal_done = 1'b1;
        evt_in.cfg_done = 1'b1;
        evt_in.lock_analog = 1'b1;
        evt_in.vco_cal_ready = 1'b1;
        evt_in.nvm_busy = 1'b1;
        evt_in.lock_freq = 1'b1;
        step();
        rdx(8'h07, 16'h0c1d);
        evt_in = '0;
        evt_in.cal_word = ~cw;
        step();
        rdx(8'h07, 16'h0002);
        // sticky unlock survives reads, cleared by recal then hard reset
        for (int i = 0; i < 2; i++) begin
            evt_in.lock_freq = 1'b1;
            step();
            step();
            evt_in.lock_freq = 1'b0;
            step();
            step();
            rdx(8'h07, 16'h0002);
            rdx(8'h07, 16'h0002);
            if (i == 0)
                evt_in.recal_start = 1'b1;
            else
                evt_in.hard_reset = 1'b1;
            step();
            evt_in.recal_start = 1'b0;
            evt_in.hard_reset = 1'b0;
            step();
            rdx(8'h07, 16'h0000);
        end
        // nvm errors in each phase, gone after one read
        for (int i = 0; i < 2; i++) begin
            evt_in.nvm_rd_phase = (i == 0);
            evt_in.nvm_wr_phase = (i == 1);
            evt_in.nvm_op_issue = 1'b1;
            step();
            evt_in.nvm_op_issue = 1'b0;
            step();
            rdx(8'h07, (i == 0) ? 16'h0200 : 16'h0100);
            rdx(8'h07, 16'h0000);
        end
        evt_in.crc_err_set = 1'b1;
        step();
        evt_in.crc_err_set = 1'b0;
        step();
        rdx(8'h07, 16'h0020);
        evt_in.crc_err_clr = 1'b1;
        step();
        evt_in.crc_err_clr = 1'b0;
        step();
        rdx(8'h07, 16'h0000);
        // accesses beyond the last register raise port errors
        req_in.rd = 1'b1;
        req_in.addr = 8'h08;
        step();
        req_in.rd = 1'b0;
        chk(rdata_out, 16'(rd_q.pop_front()));
        step();
        rdx(8'h07, 16'h0080);
        wr(8'h09, rnd());
        step();
        rdx(8'h07, 16'h00c0);
        rdx(8'h07, 16'h00c0);
        chk(outs, pd);
        srst_in = 1'b1;
        step();
        srst_in = 1'b0;
        step();
        rdx(8'h07, 16'h0000);
        chk(outs, PD_RESET);
        wrap_up();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        cyc = 0;
    end
endmodule
